// file: reset_startup_sequencer_tb.sv
// Purpose: Self-checking bench for the reset and start-up sequencer
// Assumes: Short power-on count for simulation
// Notes:   Inputs change at the falling edge
`timescale 1ns/1ps
`default_nettype none
module reset_startup_sequencer_tb;
   localparam int POR = 20;
   logic        clk = 0, srst = 1, pgood = 1, wdt = 0, stop = 0;
   logic        sel_n = 1, ext_low = 0, pin_n;
   logic [7:0]  smr_val = 8'h00;
   logic [15:0] addr = 16'h0000, saddr;
   logic        pin_out, pin_oe, irst, keep, ds_n, as_n, fstart, icode, fint, fvec;
   logic [15:0] bnd [4] = '{16'h000B, 16'h000C, 16'h0FFF, 16'h1000};
   int          fails = 0, n_compared = 0, seed = 61984, h;
   always #10 clk = ~clk;
   rss_partner i_far (.i_pull_low(ext_low), .i_dev_out(pin_out), .i_dev_oe(pin_oe),
      .o_pin_n(pin_n));
   rss_top #(.POR_CLKS(POR)) i_dut (.i_clock(clk), .i_srst(srst), .i_reset_pin_n(pin_n),
      .i_power_good(pgood), .i_watchdog_timeout(wdt), .i_stop_recovery(stop),
      .i_stop_recovery_reg(smr_val), .i_external_code_select_n(sel_n),
      .i_fetch_addr(addr), .o_reset_pin_out(pin_out), .o_reset_pin_oe(pin_oe),
      .o_internal_reset(irst), .o_preserve_mode_regs(keep), .o_data_strobe_n(ds_n),
      .o_address_strobe_n(as_n), .o_fetch_start(fstart), .o_start_addr(saddr),
      .o_internal_code_en(icode), .o_fetch_internal(fint), .o_fetch_vector(fvec));
   task automatic conclude;
      $display("compared=%0d failed=%0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask
   // Follows reset to release, then times the first fetch
   task automatic to_start(output int held);
      int   k;
      logic pa;
      held = 0;
      pa = as_n;
      while (irst === 1'b1 && held < 2000) begin
         cyc(1);
         held++;
         if (irst === 1'b1) begin
            chk(ds_n, 0);
            chk(as_n, !pa);
         end
         pa = as_n;
      end
      chk(ds_n, 1);
      chk(as_n, 1);
      k = 0;
      while (fstart !== 1'b1 && k < 20) begin
         cyc(1);
         k++;
      end
      chk(k >= 5 && k <= 10, 1);
      chk(saddr, 16'h000C);
   endtask
   task automatic por_chk;
      int n;
      n = 0;
      while (pin_oe !== 1'b1 && n < 10) begin
         cyc(1);
         n++;
      end
      n = 0;
      while (pin_oe === 1'b1 && n < 3 * POR) begin
         chk(pin_n, 0);
         cyc(1);
         n++;
      end
      chk(n >= POR - 1 && n <= POR + 1, 1);
      to_start(h);
   endtask
   initial begin
      #400000;
      fails++;
      conclude();
   end
   initial begin
      cyc(6);
      srst = 0;
      por_chk();
      for (int i = 0; i < 16; i++) begin
         addr = (i < 4) ? bnd[i] : 16'($random(seed));
         sel_n = 1'($random(seed));
         cyc(4);
         chk(icode, sel_n);
         chk(fvec, addr < 16'h000C);
         chk(fint, addr <= 16'h0FFF && sel_n);
      end
      // Two short pulses with a brief gap must not add up
      ext_low = 1;
      cyc(1 + {$random(seed)} % 3);
      ext_low = 0;
      cyc(1);
      ext_low = 1;
      cyc(3);
      ext_low = 0;
      repeat (12) begin
         cyc(1);
         chk(irst, 0);
      end
      ext_low = 1;
      cyc(9);
      chk(irst, 1);
      cyc(21);
      chk(irst, 1);
      ext_low = 0;
      to_start(h);
      pgood = 0;
      cyc(3);
      pgood = 1;
      por_chk();
      wdt = 1;
      cyc(1);
      wdt = 0;
      por_chk();
      for (int b = 0; b < 2; b++) begin
         smr_val = b ? 8'h20 : 8'h00;
         stop = 1;
         cyc(1);
         stop = 0;
         cyc(3);
         chk(irst, 1);
         chk(keep, 1);
         to_start(h);
         if (b) chk(h >= POR + 14, 1);
         else chk(h >= 12 && h <= 18, 1);
      end
      conclude();
   end
endmodule
`default_nettype wire

// file: rss_defines.svh
// Purpose: Constants for the reset and start-up sequencer
// Assumes: One 50 MHz clock stands for the external oscillator
// Notes:   Counts are in clock cycles
`ifndef RSS_DEFINES_SVH
`define RSS_DEFINES_SVH
`define RSS_CLK_PERIOD_NS    20
`define RSS_FILTER_CLKS      4
`define RSS_LATCH_CLK        5
`define RSS_HOLD_CLKS        18
`define RSS_POR_TIME_US      5000
`define RSS_POR_CLKS         ((`RSS_POR_TIME_US * 1000) / `RSS_CLK_PERIOD_NS)
`define RSS_START_DLY_MIN    5
`define RSS_START_DLY_MAX    10
`define RSS_START_ADDR       16'h000C
`define RSS_VECTOR_BYTES     12
`define RSS_INT_TOP_ADDR     16'h0FFF
`define RSS_SMR_DELAY_BIT    5
`endif

// file: rss_partner.sv
// Purpose: Far side of the reset pin: outside open-drain driver and pull-up
// Assumes: Device pin output is always low when enabled
// Notes:   Wire level worked out from both parties' enables
`timescale 1ns/1ps
`default_nettype none
module rss_partner (
   input  wire logic i_pull_low,
   input  wire logic i_dev_out,
   input  wire logic i_dev_oe,
   output logic      o_pin_n
);
   // Pull-up wins unless a party pulls low
   always_comb o_pin_n = !(i_pull_low || (i_dev_oe && !i_dev_out));
endmodule
`default_nettype wire

// file: rss_pkg.sv
// Purpose: Types for the reset and start-up sequencer
// Assumes: Nothing beyond the defines header
// Notes:   State codes are binary
package rss_pkg;
   typedef enum logic [2:0] {
      RSS_IDLE    = 3'b000,
      RSS_QUAL    = 3'b001,
      RSS_HOLD    = 3'b010,
      RSS_POR     = 3'b011,
      RSS_START   = 3'b100
   } rss_state_t;
endpackage

// file: rss_top.sv
// Purpose: Reset filtering, stretching, sources and start-up release
// Assumes: Power-on, watchdog and stop-recovery causes are one-cycle pulses
// Notes:   Reset pin is open-drain: output low with enable when driven
`timescale 1ns/1ps
`default_nettype none
`include "rss_defines.svh"

module rss_top #(
   parameter int unsigned POR_CLKS = `RSS_POR_CLKS
) (
   input  wire logic              i_clock,
   input  wire logic              i_srst,
   input  wire logic              i_reset_pin_n,
   input  wire logic              i_power_good,
   input  wire logic              i_watchdog_timeout,
   input  wire logic              i_stop_recovery,
   input  wire logic [7:0]        i_stop_recovery_reg,
   input  wire logic              i_external_code_select_n,
   input  wire logic [15:0]       i_fetch_addr,
   output logic                   o_reset_pin_out,
   output logic                   o_reset_pin_oe,
   output logic                   o_internal_reset,
   output logic                   o_preserve_mode_regs,
   output logic                   o_data_strobe_n,
   output logic                   o_address_strobe_n,
   output logic                   o_fetch_start,
   output logic [15:0]            o_start_addr,
   output logic                   o_internal_code_en,
   output logic                   o_fetch_internal,
   output logic                   o_fetch_vector
);
   import rss_pkg::*;

   logic        pin_meta;
   logic        pin_sync_n;
   logic        pg_meta;
   logic        pg_sync;
   logic        pg_prev;
   logic        sel_meta;
   logic        sel_sync_n;
   logic [2:0]  filt_cnt;
   logic [4:0]  hold_cnt;
   logic [22:0] por_cnt;
   logic [3:0]  start_cnt;
   logic        por_drive;
   logic        stop_cause;
   logic        por_trigger;
   logic        soft_trigger;
   logic        pin_asserted;
   rss_state_t  state;
   rss_state_t  next_state;

   // Two-stage synchronisers for pins
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         pin_meta   <= 1'b1;
         pin_sync_n <= 1'b1;
         pg_meta    <= 1'b0;
         pg_sync    <= 1'b0;
         sel_meta   <= 1'b1;
         sel_sync_n <= 1'b1;
      end else begin
         pin_meta   <= i_reset_pin_n;
         pin_sync_n <= pin_meta;
         pg_meta    <= i_power_good;
         pg_sync    <= pg_meta;
         sel_meta   <= i_external_code_select_n;
         sel_sync_n <= sel_meta;
      end
   end

   // Own pull-down is not an outside reset
   assign pin_asserted = !pin_sync_n && !por_drive;

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         pg_prev <= 1'b0;
      end else begin
         pg_prev <= pg_sync;
      end
   end

   // One-shot triggers from internal causes
   assign por_trigger  = (pg_sync && !pg_prev) || i_watchdog_timeout
                         || (i_stop_recovery && i_stop_recovery_reg[`RSS_SMR_DELAY_BIT]);
   assign soft_trigger = i_stop_recovery && !i_stop_recovery_reg[`RSS_SMR_DELAY_BIT];

   // Filter counter: qualifies pin low for five clocks in RSS_QUAL
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         filt_cnt <= 3'h0;
      end else if (!pin_asserted || state != RSS_QUAL) begin
         filt_cnt <= 3'h0;
      end else if (filt_cnt != 3'(`RSS_LATCH_CLK)) begin
         filt_cnt <= filt_cnt + 3'h1;
      end
   end

   always_comb begin
      next_state = state;
      case (state)
         RSS_IDLE, RSS_START: begin
            if (por_trigger) begin
               next_state = RSS_POR;
            end else if (soft_trigger) begin
               next_state = RSS_HOLD;
            end else if (pin_asserted && state == RSS_IDLE) begin
               next_state = RSS_QUAL;
            end else if (state == RSS_START && start_cnt == 4'(`RSS_START_DLY_MIN)) begin
               next_state = RSS_IDLE;
            end
         end
         RSS_QUAL: begin
            if (por_trigger) begin
               next_state = RSS_POR;
            end else if (!pin_asserted) begin
               next_state = RSS_IDLE;
            end else if (filt_cnt == 3'(`RSS_LATCH_CLK - 1)) begin
               next_state = RSS_HOLD;
            end
         end
         RSS_HOLD: begin
            if (por_trigger) begin
               next_state = RSS_POR;
            end else if (hold_cnt >= 5'(`RSS_HOLD_CLKS - 1) && !pin_asserted) begin
               next_state = RSS_START;
            end
         end
         RSS_POR: begin
            if (por_cnt == 23'(POR_CLKS - 1)) begin
               next_state = RSS_HOLD;
            end
         end
         default: next_state = RSS_IDLE;
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         state <= RSS_POR;
      end else begin
         state <= next_state;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst || state != RSS_HOLD) begin
         hold_cnt <= 5'h00;
      end else if (hold_cnt != 5'h1F) begin
         hold_cnt <= hold_cnt + 5'h01;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst || state != RSS_POR) begin
         por_cnt <= 23'h000000;
      end else begin
         por_cnt <= por_cnt + 23'h000001;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst || state != RSS_START) begin
         start_cnt <= 4'h0;
      end else begin
         start_cnt <= start_cnt + 4'h1;
      end
   end

   // Pin pull-down lasts exactly the power-on delay
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         por_drive <= 1'b1;
      end else begin
         por_drive <= (next_state == RSS_POR);
      end
   end

   // Stop-recovery cause tells the core to keep mode registers
   // Set wins, also when stop recovery runs the power-on delay
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         stop_cause <= 1'b0;
      end else if (i_stop_recovery) begin
         stop_cause <= 1'b1;
      end else if (por_trigger || state == RSS_QUAL) begin
         stop_cause <= 1'b0;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_internal_reset   <= 1'b1;
         o_data_strobe_n    <= 1'b0;
         o_address_strobe_n <= 1'b1;
         o_fetch_start      <= 1'b0;
         o_reset_pin_out    <= 1'b0;
         o_reset_pin_oe     <= 1'b1;
      end else begin
         o_internal_reset <= (next_state == RSS_HOLD) || (next_state == RSS_POR);
         if ((next_state == RSS_HOLD) || (next_state == RSS_POR)) begin
            o_data_strobe_n    <= 1'b0;
            o_address_strobe_n <= !o_address_strobe_n;
         end else begin
            o_data_strobe_n    <= 1'b1;
            o_address_strobe_n <= 1'b1;
         end
         o_fetch_start   <= (state == RSS_START) && (next_state == RSS_IDLE);
         o_reset_pin_out <= 1'b0;
         o_reset_pin_oe  <= (next_state == RSS_POR);
      end
   end

   // Memory map outputs
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_start_addr         <= `RSS_START_ADDR;
         o_internal_code_en   <= 1'b1;
         o_fetch_internal     <= 1'b0;
         o_fetch_vector       <= 1'b0;
         o_preserve_mode_regs <= 1'b0;
      end else begin
         o_start_addr         <= `RSS_START_ADDR;
         o_internal_code_en   <= sel_sync_n;
         o_fetch_internal     <= sel_sync_n && (i_fetch_addr <= `RSS_INT_TOP_ADDR);
         o_fetch_vector       <= (i_fetch_addr < 16'(`RSS_VECTOR_BYTES));
         o_preserve_mode_regs <= stop_cause;
      end
   end

   // Checks
   sequence s_latch;
      state == RSS_QUAL && pin_asserted ##1 (state == RSS_QUAL && pin_asserted) [*4];
   endsequence

   // Release seen, then no new cause while the start delay runs
   sequence s_released;
      $fell(o_internal_reset) && !por_trigger && !soft_trigger
      ##1 (!por_trigger && !soft_trigger) [*5];
   endsequence

   chk_filter_short: assert property (@(posedge i_clock) disable iff (i_srst)
      state == RSS_QUAL && !pin_asserted |=> state != RSS_HOLD)
      else $error("short pin pulse latched reset");
   chk_latch_fifth: assert property (@(posedge i_clock) disable iff (i_srst)
      s_latch and (!por_trigger [*5]) |=> state == RSS_HOLD)
      else $error("reset not latched on fifth clock");
   chk_hold_min: assert property (@(posedge i_clock) disable iff (i_srst)
      state == RSS_HOLD && !por_trigger && hold_cnt < 5'(`RSS_HOLD_CLKS - 1)
      |=> state == RSS_HOLD)
      else $error("reset hold too short");
   chk_hold_pin: assert property (@(posedge i_clock) disable iff (i_srst)
      state == RSS_HOLD && pin_asserted && !por_trigger |=> state == RSS_HOLD)
      else $error("reset released while pin low");
   chk_strobe_hold: assert property (@(posedge i_clock) disable iff (i_srst)
      o_internal_reset && $past(o_internal_reset) && !$past(i_srst) |-> !o_data_strobe_n
      && (o_address_strobe_n != $past(o_address_strobe_n)))
      else $error("strobes wrong during reset");
   chk_start_delay: assert property (@(posedge i_clock) disable iff (i_srst)
      s_released |-> ##[0:5] o_fetch_start)
      else $error("fetch not within five to ten clocks");
   chk_start_addr: assert property (@(posedge i_clock) disable iff (i_srst)
      o_fetch_start |-> o_start_addr == `RSS_START_ADDR)
      else $error("fetch start address wrong");
   chk_pin_drive: assert property (@(posedge i_clock) disable iff (i_srst)
      o_reset_pin_oe |-> o_internal_reset && !o_reset_pin_out)
      else $error("pin driven outside reset");
   chk_por_end: assert property (@(posedge i_clock) disable iff (i_srst)
      state == RSS_POR && por_cnt == 23'(POR_CLKS - 1) |=> state == RSS_HOLD)
      else $error("power-on delay end wrong");
   chk_rom_select: assert property (@(posedge i_clock) disable iff (i_srst)
      ##1 o_internal_code_en == $past(sel_sync_n))
      else $error("code select not followed");
   chk_stop_delay: assert property (@(posedge i_clock) disable iff (i_srst)
      i_stop_recovery && i_stop_recovery_reg[`RSS_SMR_DELAY_BIT] |=> state == RSS_POR)
      else $error("stop delay not run");
   chk_filter_clear: assert property (@(posedge i_clock) disable iff (i_srst)
      !pin_asserted |=> filt_cnt == 3'h0)
      else $error("filter not cleared");
   chk_external_map: assert property (@(posedge i_clock) disable iff (i_srst)
      !o_internal_code_en |-> !o_fetch_internal)
      else $error("internal fetch in external code mode");
   chk_keep_modes: assert property (@(posedge i_clock) disable iff (i_srst)
      i_stop_recovery |-> ##2 o_preserve_mode_regs)
      else $error("mode registers not kept on stop recovery");
endmodule
`default_nettype wire
